// [rtl/scg_map.svh]
// Register map, field positions and timing constants of the supervisor configuration block
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_ADDR_PROT      8'h0d
`define SCG_ADDR_OSC       8'h0e
`define SCG_ADDR_PIN0      8'h10
`define SCG_PROT_RST       8'h00
`define SCG_OSC_RST        8'h00
`define SCG_PIN0_RST       8'h00
`define SCG_PROT_MASK      8'h7c
`define SCG_OSC_MASK       8'h72
`define SCG_PIN0_MASK      8'h1f
`define SCG_DLY_HI         6
`define SCG_DLY_LO         5
`define SCG_OCMASK_BIT     4
`define SCG_PGM_HI         3
`define SCG_PGM_LO         2
`define SCG_TRIM_HI        6
`define SCG_TRIM_LO        4
`define SCG_TOUT_BIT       1
`define SCG_FUNC_HI        4
`define SCG_FUNC_LO        1
`define SCG_OBUF_BIT       0
`define SCG_CLK_KHZ        40000
`define SCG_T1_NS          8000
`define SCG_T2_US          1000
`define SCG_T3_US          3000
`define SCG_TOUT_MS        50
`define SCG_STEP_KHZ       160
`define SCG_CNT1 ((`SCG_T1_NS * `SCG_CLK_KHZ + 999999) / 1000000)
`define SCG_CNT2 ((`SCG_T2_US * `SCG_CLK_KHZ + 999) / 1000)
`define SCG_CNT3 ((`SCG_T3_US * `SCG_CLK_KHZ + 999) / 1000)
`define SCG_CNTT (`SCG_TOUT_MS * `SCG_CLK_KHZ)
`define SCG_PGM_NONE       2'h0
`define SCG_PGM_LOW        2'h1
`define SCG_PGM_HIGH       2'h2
`endif

// [rtl/scg_pin_if.sv]
// Configuration and live signals carried from the register bank to the pin mux
`timescale 1ns/10ps
interface scg_pin_if;
	logic [3:0] func;
	logic       obuf;
	logic       pg;
	logic       irq;
	modport bank (output func, output obuf, output pg, output irq);
	modport mux  (input func, input obuf, input pg, input irq);
endinterface : scg_pin_if

// [rtl/scg_pin_mux.sv]
// Function and output-buffer select of general-purpose pin 0
`timescale 1ns/10ps
module scg_pin_mux (
	scg_pin_if.mux    cfg,
	input  wire logic pin_in,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      enable_in,
	output logic      select_in,
	output logic      reload_in
);
	import scg_pkg::*;

	function automatic logic is_out(input logic [3:0] f);
		is_out = (f == SCG_FN_PG_OUT) || (f == SCG_FN_IRQ_OUT) ||
			(f == SCG_FN_LOW) || (f == SCG_FN_HIGH);
	endfunction : is_out

	logic lvl;

	always_comb begin
		case (cfg.func)
			SCG_FN_PG_OUT:  lvl = cfg.pg;
			SCG_FN_IRQ_OUT: lvl = ~cfg.irq;
			SCG_FN_LOW:     lvl = 1'b0;
			SCG_FN_HIGH:    lvl = 1'b1;
			default:        lvl = 1'b0;
		endcase
	end

	// Open drain only pulls low; push-pull drives both levels
	assign pin_out   = lvl;
	assign pin_oe    = is_out(cfg.func) && (cfg.obuf || !lvl);
	// Inputs sampled only in their own role, reserved codes sample nothing
	assign enable_in = (cfg.func == SCG_FN_EN_IN)  && pin_in;
	assign select_in = (cfg.func == SCG_FN_VS_IN)  && pin_in;
	assign reload_in = (cfg.func == SCG_FN_RLD_IN) && pin_in;
endmodule : scg_pin_mux

// [rtl/scg_pkg.sv]
// Types shared by the supervisor configuration block
package scg_pkg;
	typedef enum logic [3:0] {
		SCG_FN_OFF    = 4'h0,
		SCG_FN_EN_IN  = 4'h1,
		SCG_FN_VS_IN  = 4'h4,
		SCG_FN_RLD_IN = 4'h7,
		SCG_FN_PG_OUT = 4'h8,
		SCG_FN_IRQ_OUT = 4'hc,
		SCG_FN_LOW    = 4'he,
		SCG_FN_HIGH   = 4'hf
	} scg_func_t;
	typedef enum {SCG_OC_IDLE, SCG_OC_COUNT, SCG_OC_LATCHED} scg_oc_state_t;
endpackage : scg_pkg

// [rtl/scg_supervisor.sv]
// Supervisor configuration register bank with latch-off timer and pin 0 mux
`timescale 1ns/10ps
`include "scg_map.svh"
module scg_supervisor (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	output logic      [7:0]  reg_rdata,
	input  wire logic        overcurrent_signal,
	input  wire logic        dynamic_voltage_ramp,
	input  wire logic        power_good_raw,
	input  wire logic        overcurrent_irq_mask,
	input  wire logic        irq_other,
	input  wire logic        sda_in,
	input  wire logic        converter_restart,
	output logic             converter_shutdown,
	output logic             interrupt_request_out,
	output logic             power_good_output,
	output logic signed [10:0] trim_offset_khz,
	output logic             bus_reset,
	input  wire logic        pin0_in,
	output logic             pin0_out,
	output logic             pin0_oe,
	output logic             converter_enable_input,
	output logic             voltage_select_input,
	output logic             reload_input
);
	import scg_pkg::*;

	localparam int CNT1 = `SCG_CNT1;
	localparam int CNT2 = `SCG_CNT2;
	localparam int CNT3 = `SCG_CNT3;
	localparam int CNTT = `SCG_CNTT;

	logic [7:0]    protection_config_ff;
	logic [7:0]    oscillator_bus_config_ff;
	logic [7:0]    pin0_function_select_ff;
	scg_oc_state_t oc_state_ff;
	scg_oc_state_t nxt_oc_state;
	logic [16:0]   oc_cnt_ff;
	logic [16:0]   nxt_oc_cnt;
	logic [16:0]   oc_limit;
	logic [21:0]   tout_cnt_ff;
	logic          irq_ff;
	logic          nxt_irq;
	logic          pg_ff;
	logic          bus_reset_ff;
	logic          oc_active;
	logic [1:0]    dly_sel;
	logic [1:0]    pgm_sel;
	logic [8:0]    held_cnt_ff;

	//***********************************************************
	// Register access
	//***********************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			protection_config_ff     <= `SCG_PROT_RST;
			oscillator_bus_config_ff <= `SCG_OSC_RST;
			pin0_function_select_ff  <= `SCG_PIN0_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`SCG_ADDR_PROT: protection_config_ff     <= reg_wdata & `SCG_PROT_MASK;
				`SCG_ADDR_OSC:  oscillator_bus_config_ff <= reg_wdata & `SCG_OSC_MASK;
				`SCG_ADDR_PIN0: pin0_function_select_ff  <= reg_wdata & `SCG_PIN0_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`SCG_ADDR_PROT: reg_rdata <= protection_config_ff;
				`SCG_ADDR_OSC:  reg_rdata <= oscillator_bus_config_ff;
				`SCG_ADDR_PIN0: reg_rdata <= pin0_function_select_ff;
				default:        reg_rdata <= 8'h00;
			endcase
		end
	end

	assign dly_sel = protection_config_ff[`SCG_DLY_HI:`SCG_DLY_LO];
	assign pgm_sel = protection_config_ff[`SCG_PGM_HI:`SCG_PGM_LO];

	//***********************************************************
	// Over-current latch-off
	//***********************************************************
	// Ramp masking hides over-current from both timer and interrupt
	assign oc_active = overcurrent_signal &&
		!(protection_config_ff[`SCG_OCMASK_BIT] && dynamic_voltage_ramp);

	always_comb begin
		case (dly_sel)
			2'h1:    oc_limit = 17'(CNT1);
			2'h2:    oc_limit = 17'(CNT2);
			2'h3:    oc_limit = 17'(CNT3);
			default: oc_limit = 17'h00000;
		endcase
	end

	always_comb begin
		nxt_oc_state = oc_state_ff;
		nxt_oc_cnt   = oc_cnt_ff;
		nxt_irq      = irq_ff;
		case (oc_state_ff)
			SCG_OC_IDLE: begin
				nxt_oc_cnt = 17'h00000;
				if (oc_active && dly_sel != 2'h0) begin
					nxt_oc_state = SCG_OC_COUNT;
					nxt_oc_cnt   = 17'h00001;
				end
			end
			SCG_OC_COUNT: begin
				if (!oc_active || dly_sel == 2'h0) begin
					nxt_oc_state = SCG_OC_IDLE;
					nxt_oc_cnt   = 17'h00000;
				end else if (oc_cnt_ff >= oc_limit) begin
					nxt_oc_state = SCG_OC_LATCHED;
					nxt_irq      = 1'b1;
				end else begin
					nxt_oc_cnt = oc_cnt_ff + 17'h00001;
				end
			end
			SCG_OC_LATCHED: begin
				if (converter_restart) begin
					nxt_oc_state = SCG_OC_IDLE;
					nxt_oc_cnt   = 17'h00000;
					nxt_irq      = 1'b0;
				end
			end
			default: nxt_oc_state = SCG_OC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			oc_state_ff <= SCG_OC_IDLE;
			oc_cnt_ff   <= 17'h00000;
			irq_ff      <= 1'b0;
		end else begin
			oc_state_ff <= nxt_oc_state;
			oc_cnt_ff   <= nxt_oc_cnt;
			irq_ff      <= nxt_irq;
		end
	end

	assign converter_shutdown    = (oc_state_ff == SCG_OC_LATCHED);
	assign interrupt_request_out = (irq_ff && !overcurrent_irq_mask) || irq_other;

	//***********************************************************
	// Power-good ramp mask
	//***********************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pg_ff <= 1'b0;
		end else if (dynamic_voltage_ramp && pgm_sel == `SCG_PGM_LOW) begin
			pg_ff <= 1'b0;
		end else if (dynamic_voltage_ramp && pgm_sel == `SCG_PGM_HIGH) begin
			pg_ff <= 1'b1;
		end else begin
			pg_ff <= power_good_raw;
		end
	end
	assign power_good_output = pg_ff;

	//***********************************************************
	// Oscillator trim
	//***********************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trim_offset_khz <= 11'sh000;
		end else begin
			trim_offset_khz <= 11'($signed(oscillator_bus_config_ff[`SCG_TRIM_HI:`SCG_TRIM_LO]))
				* 11'(`SCG_STEP_KHZ);
		end
	end

	//***********************************************************
	// Serial bus data-low timeout
	//***********************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tout_cnt_ff  <= 22'h000000;
			bus_reset_ff <= 1'b0;
		end else if (!oscillator_bus_config_ff[`SCG_TOUT_BIT] || sda_in) begin
			tout_cnt_ff  <= 22'h000000;
			bus_reset_ff <= 1'b0;
		end else if (tout_cnt_ff > 22'(CNTT)) begin
			tout_cnt_ff  <= 22'h000000;
			bus_reset_ff <= 1'b1;
		end else begin
			tout_cnt_ff  <= tout_cnt_ff + 22'h000001;
			bus_reset_ff <= 1'b0;
		end
	end
	assign bus_reset = bus_reset_ff;

	//***********************************************************
	// Pin 0 mux
	//***********************************************************
	scg_pin_if pin_cfg ();
	assign pin_cfg.func = pin0_function_select_ff[`SCG_FUNC_HI:`SCG_FUNC_LO];
	assign pin_cfg.obuf = pin0_function_select_ff[`SCG_OBUF_BIT];
	assign pin_cfg.pg   = pg_ff;
	assign pin_cfg.irq  = interrupt_request_out;

	scg_pin_mux u_pin_mux (
		.cfg       (pin_cfg),
		.pin_in    (pin0_in),
		.pin_out   (pin0_out),
		.pin_oe    (pin0_oe),
		.enable_in (converter_enable_input),
		.select_in (voltage_select_input),
		.reload_in (reload_input)
	);

	//***********************************************************
	// Checks
	//***********************************************************
	// Independent run length of unmasked over-current at the shortest setting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			held_cnt_ff <= 9'h000;
		end else if (!oc_active || dly_sel != 2'h1 || converter_shutdown) begin
			held_cnt_ff <= 9'h000;
		end else if (held_cnt_ff != 9'(CNT1)) begin
			held_cnt_ff <= held_cnt_ff + 9'h001;
		end
	end

	sequence s_oc_held;
		held_cnt_ff == 9'(CNT1) && oc_active && dly_sel == 2'h1 && !converter_restart;
	endsequence

	a_latch_8us: assert property (@(posedge clk) disable iff (!resetn)
		s_oc_held |=> converter_shutdown)
		else $error("latch-off did not follow 8 us over-current");
	a_no_latch_off: assert property (@(posedge clk) disable iff (!resetn)
		dly_sel == 2'h0 && oc_state_ff != SCG_OC_LATCHED |=> !converter_shutdown)
		else $error("latch-off while disabled");
	a_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
		$rose(converter_shutdown) && !overcurrent_irq_mask |-> interrupt_request_out)
		else $error("latch-off without interrupt");
	a_ramp_oc_mask: assert property (@(posedge clk) disable iff (!resetn)
		protection_config_ff[`SCG_OCMASK_BIT] && dynamic_voltage_ramp
		&& oc_state_ff != SCG_OC_LATCHED |=> !converter_shutdown)
		else $error("latch-off during masked ramp");
	a_pg_low_mask: assert property (@(posedge clk) disable iff (!resetn)
		dynamic_voltage_ramp && pgm_sel == `SCG_PGM_LOW |=> !power_good_output)
		else $error("power good during masked ramp");
	a_pg_high_mask: assert property (@(posedge clk) disable iff (!resetn)
		dynamic_voltage_ramp && pgm_sel == `SCG_PGM_HIGH |=> power_good_output)
		else $error("power good not forced during ramp");
	a_trim_value: assert property (@(posedge clk) disable iff (!resetn)
		$stable(oscillator_bus_config_ff) |=> trim_offset_khz ==
		11'($signed($past(oscillator_bus_config_ff[`SCG_TRIM_HI:`SCG_TRIM_LO])) * `SCG_STEP_KHZ))
		else $error("trim offset wrong");
	a_trim_neg: assert property (@(posedge clk) disable iff (!resetn)
		oscillator_bus_config_ff[6:4] == 3'h4 |=> trim_offset_khz < 0)
		else $error("trim code 4 not negative");
	a_tout_quiet: assert property (@(posedge clk) disable iff (!resetn)
		sda_in |=> !bus_reset)
		else $error("bus reset with data high");
	a_oc_restart: assert property (@(posedge clk) disable iff (!resetn)
		oc_state_ff == SCG_OC_COUNT && !oc_active |=> oc_cnt_ff == 17'h00000)
		else $error("counter not restarted");
	a_pin_reserved: assert property (@(posedge clk) disable iff (!resetn)
		pin0_function_select_ff[4:1] == 4'h2 |-> !pin0_oe && !converter_enable_input)
		else $error("reserved code not disabled");
	a_od_release: assert property (@(posedge clk) disable iff (!resetn)
		!pin0_function_select_ff[0] && pin0_oe |-> !pin0_out)
		else $error("open drain drove high");
	a_pin_high_drive: assert property (@(posedge clk) disable iff (!resetn)
		pin_cfg.func == SCG_FN_HIGH && pin_cfg.obuf |-> pin0_oe && pin0_out)
		else $error("high output not driven");
	a_pin_irq_level: assert property (@(posedge clk) disable iff (!resetn)
		pin_cfg.func == SCG_FN_IRQ_OUT && pin0_oe |-> pin0_out == !interrupt_request_out)
		else $error("interrupt pin level wrong");
endmodule : scg_supervisor

// [tb/scg_host_model.sv]
// Host processor model issuing register writes and reads to the supervisor block
`timescale 1ns/10ps
module scg_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr
);
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
	end

	// Data is scrambled after the strobe so a late sample cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	// Returns at the edge that loads the read data
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
	endtask : rd
endmodule : scg_host_model

// [tb/tb.sv]
// Self-checking bench of the supervisor configuration block
`timescale 1ns/10ps
`include "scg_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
	logic        clk, resetn, oc, ramp, pg_raw, oc_mask, irq_oth, sda, restart, pin_in;
	logic [7:0]  addr, wdata, rdata;
	logic        wr, shut, irq, pg, bres, p_out, p_oe, en_in, vs_in, rl_in, drv, x_oe;
	logic signed [10:0] trim, ex;
	logic [7:0]  adr[4] = '{8'h0d, 8'h0e, 8'h10, 8'h11};
	logic [7:0]  msk[4] = '{8'h7c, 8'h72, 8'h1f, 8'h00};
	string       nm[11] = '{"rdata", "shutdown", "irq", "pg", "trim", "bus_reset", "pin_oe",
		"pin_out", "enable", "select", "reload"};
	int          n_fail, checks_done, q_sel[$];
	logic [10:0] q_exp[$];
	integer      seed = 32'hf294dc9c;

	scg_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr));
	scg_supervisor i_dut (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rdata(rdata), .overcurrent_signal(oc), .dynamic_voltage_ramp(ramp),
		.power_good_raw(pg_raw), .overcurrent_irq_mask(oc_mask), .irq_other(irq_oth),
		.sda_in(sda), .converter_restart(restart), .converter_shutdown(shut),
		.interrupt_request_out(irq), .power_good_output(pg), .trim_offset_khz(trim),
		.bus_reset(bres), .pin0_in(pin_in), .pin0_out(p_out), .pin0_oe(p_oe),
		.converter_enable_input(en_in), .voltage_select_input(vs_in), .reload_input(rl_in));

	// ****************************************
	// Clock, watcher and helpers
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [10:0] got(int s);
		case (s)
			0: return {3'h0, rdata};
			1: return {10'h0, shut};
			2: return {10'h0, irq};
			3: return {10'h0, pg};
			4: return trim;
			5: return {10'h0, bres};
			6: return {10'h0, p_oe};
			7: return {10'h0, p_out};
			8: return {10'h0, en_in};
			9: return {10'h0, vs_in};
			default: return {10'h0, rl_in};
		endcase
	endfunction : got

	always @(negedge clk) begin
		while (q_sel.size() > 0) begin
			`CHK(nm[q_sel[0]], q_exp[0], got(q_sel[0]))
			void'(q_sel.pop_front());
			void'(q_exp.pop_front());
		end
	end

	task automatic note(input int s, input logic [10:0] e);
		q_sel.push_back(s);
		q_exp.push_back(e);
		@(negedge clk);
	endtask : note

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Leaves latch-off and confirms the converter runs again
	task automatic rel();
		@(posedge clk) begin restart <= 1'b1; oc <= 1'b0; end
		@(posedge clk) restart <= 1'b0;
		cyc(2);
		note(1, 0);
	endtask : rel

	task summarize;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		summarize();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{resetn, oc, ramp, pg_raw, oc_mask, irq_oth, restart, pin_in} = 8'h00;
		sda = 1'b1;
		cyc(20);
		@(posedge clk) resetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			i_host.rd(adr[i]);
			note(0, 0);
			i_host.wr(adr[i], 8'hff);
			i_host.rd(adr[i]);
			note(0, {3'h0, msk[i]});
		end
		@(posedge clk) sda <= 1'b0;
		cyc(1000);
		note(5, 0);
		@(posedge clk) sda <= 1'b1;
		for (int t = 0; t < 8; t++) begin
			i_host.wr(`SCG_ADDR_OSC, {1'b0, 3'(t), 4'h0});
			cyc(3);
			ex = $signed(3'(t)) * 11'sd160;
			note(4, ex);
		end
		for (int m = 0; m < 4; m++) for (int r = 0; r < 2; r++) begin
			i_host.wr(`SCG_ADDR_PROT, {4'h0, 2'(m), 2'h0});
			@(posedge clk) begin ramp <= 1'(r); pg_raw <= 1'($random(seed)); end
			cyc(3);
			note(3, (r == 0 || m == 0 || m == 3) ? pg_raw : (m == 2));
		end
		@(posedge clk) ramp <= 1'b0;
		for (int c = 0; c < 16; c++) for (int b = 0; b < 2; b++) begin
			@(posedge clk) begin
				pin_in  <= 1'($random(seed));
				irq_oth <= 1'($random(seed));
				pg_raw  <= 1'($random(seed));
			end
			i_host.wr(`SCG_ADDR_PIN0, {3'h0, 4'(c), 1'(b)});
			cyc(3);
			drv  = (c == 15) | (c == 8 & pg_raw) | (c == 12 & !irq_oth);
			x_oe = (c == 8 | c == 12 | c == 14 | c == 15) & (b == 1 | !drv);
			note(6, x_oe);
			if (x_oe) note(7, drv);
			note(8, c == 1 & pin_in);
			note(9, c == 4 & pin_in);
			note(10, c == 7 & pin_in);
		end
		@(posedge clk) irq_oth <= 1'b0;
		i_host.wr(`SCG_ADDR_PROT, 8'h20);
		@(posedge clk) oc <= 1'b1;
		cyc(200);
		@(posedge clk) oc <= 1'b0;
		@(posedge clk) oc <= 1'b1;
		cyc(310);
		note(1, 0);
		cyc(20);
		note(1, 1);
		note(2, 1);
		@(posedge clk) oc_mask <= 1'b1;
		cyc(1);
		note(2, 0);
		@(posedge clk) irq_oth <= 1'b1;
		cyc(1);
		note(2, 1);
		@(posedge clk) begin irq_oth <= 1'b0; oc_mask <= 1'b0; end
		rel();
		i_host.wr(`SCG_ADDR_PROT, 8'h40);
		@(posedge clk) oc <= 1'b1;
		cyc(39990);
		note(1, 0);
		cyc(20);
		note(1, 1);
		rel();
		i_host.wr(`SCG_ADDR_PROT, 8'h30);
		@(posedge clk) begin ramp <= 1'b1; oc <= 1'b1; end
		cyc(400);
		note(1, 0);
		note(2, 0);
		@(posedge clk) ramp <= 1'b0;
		cyc(330);
		note(1, 1);
		rel();
		summarize();
	end
endmodule : tb
